// ### verilog/t1_j1_frame_generator_regs.svh
// Constants of the T1/J1 frame generator: frame geometry, patterns, positions.
// Assumes inclusion by bare name from the frame generator module only.
`ifndef T1_J1_FRAME_GENERATOR_REGS_SVH
`define T1_J1_FRAME_GENERATOR_REGS_SVH
`define FG_LAST_BIT 8'd192
`define FG_CH24_FIRST 8'd185
`define FG_SF_LAST_FRAME 5'd11
`define FG_ESF_LAST_FRAME 5'd23
`define FG_SF_ALIGN 12'h8DC
`define FG_SF_ALIGN_TOP 4'd11
`define FG_ESF_ALIGN 6'h0B
`define FG_ESF_ALIGN_TOP 3'd5
`define FG_ESF_ALIGN_PHASE 2'd3
`define FG_ESF_CRC_PHASE 2'd1
`define FG_ESF_FIRST_CRC_FRAME 5'd1
`define FG_CRC_POLY 6'h03
`define FG_T1_IDLE 16'hFFFF
`define FG_J1_IDLE 16'hFF7E
`define FG_T1_YELLOW 16'hFF00
`define FG_J1_YELLOW 16'hFFFF
`define FG_DL_TOP 4'hF
`define FG_DDS_PATTERN 8'h1D
`define FG_DDS_TOP 3'd7
`define FG_YELLOW_OFS 3'd1
`define FG_DM_D_OFS 3'd1
`define FG_DM_Y_OFS 3'd2
`define FG_FIFO_DEPTH 4
`endif

// ### verilog/t1_j1_frame_generator_pkg.sv
// Types shared by the T1/J1 frame generator modules.
// Assumes nothing of its surroundings.
package t1_j1_frame_generator_pkg;
  typedef enum logic [1:0] {
    FMT_SF = 2'b00,
    FMT_ESF = 2'b01,
    FMT_DM = 2'b10
  } format_type;
endpackage

// ### verilog/stream_if.sv
// Valid/ready word stream between the generator and its input FIFO.
// Assumes both ends share one clock.
`timescale 1ns/1ns
`default_nettype none
interface stream_if #(parameter int WIDTH = 2);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ### verilog/fifo_buffer.sv
// Small synchronous FIFO with registered full and empty.
// Assumes one clock, a clock enable and an asynchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none
module fifo_buffer #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 4
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  stream_if.snk fill,
  stream_if.src drain
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic full_q, full_d, empty_q, empty_d;
  logic room_q;
  logic push, pop;

  assign push = i_ce & fill.valid & ~full_q;
  assign pop = i_ce & drain.ready & ~empty_q;
  // Ready is a flop of its own so that it can leave the top module directly.
  assign fill.ready = room_q;
  assign drain.valid = ~empty_q;
  assign drain.data = mem[rd_q];

  always_comb begin
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
    end
    if (pop) begin
      rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
    end
    if (push & ~pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop & ~push) begin
      cnt_d = cnt_q - 1'b1;
    end
    full_d = (cnt_d == CW'(DEPTH));
    empty_d = (cnt_d == '0);
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      full_q <= 1'b0;
      room_q <= 1'b1;
      empty_q <= 1'b1;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      full_q <= full_d;
      room_q <= ~full_d;
      empty_q <= empty_d;
    end
  end

  // Storage has no reset; only words marked valid by the pointers are read.
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_q] <= fill.data;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  a_fifo_no_overfill: assert property (full_q |-> cnt_q == CW'(DEPTH))
    else $error("fifo full flag disagrees with its count");
endmodule
`default_nettype wire

// ### verilog/t1_j1_frame_generator.sv
// T1/J1 transmit frame generator: overwrites overhead bits of a serial stream.
// Assumes one bit per accepted word, I_FRAME_PULSE on the first bit of a multiframe.
`timescale 1ns/1ns
`default_nettype none
`include "t1_j1_frame_generator_regs.svh"
module t1_j1_frame_generator #(
  parameter int FIFO_DEPTH = `FG_FIFO_DEPTH
) (
  input wire logic I_CLK,
  input wire logic I_NRST,
  input wire logic I_CE,
  input wire logic I_DATA,
  input wire logic I_FRAME_PULSE,
  input wire logic I_VALID,
  output logic O_READY,
  output logic O_DATA,
  output logic O_VALID,
  input wire logic I_OUT_READY,
  input wire logic [1:0] I_FORMAT,
  input wire logic I_J1_MODE,
  input wire logic I_FRAMING_DISABLE,
  input wire logic I_TERMINAL_FRAMING_INVERT,
  input wire logic I_SIGNALING_FRAMING_INVERT,
  input wire logic I_CRC_PATTERN_INVERT,
  input wire logic I_DDS_PATTERN_INVERT,
  input wire logic I_COPY_FRAMING_BIT_ENABLE,
  input wire logic I_MANUAL_YELLOW_SEND,
  input wire logic I_AUTO_REMOTE_ALARM_ENABLE,
  input wire logic I_RED_ALARM,
  input wire logic I_CRC_INSERT_BYPASS,
  input wire logic I_DATA_LINK_BYPASS,
  input wire logic I_BOC_VALID,
  input wire logic I_BOC_BIT,
  input wire logic I_PRM_VALID,
  input wire logic I_PRM_BIT,
  input wire logic I_HDLC_VALID,
  input wire logic I_HDLC_BIT,
  output logic O_HDLC_TAKE,
  input wire logic I_BASIC_FRAME_FLAG_CLR,
  input wire logic I_MULTIFRAME_FLAG_CLR,
  input wire logic I_BASIC_FRAME_IRQ_ENABLE,
  input wire logic I_MULTIFRAME_IRQ_ENABLE,
  output logic O_BASIC_FRAME_FLAG,
  output logic O_MULTIFRAME_FLAG,
  output logic O_IRQ,
  output logic O_YELLOW_ACTIVE,
  output logic [3:0] O_INVERT_PENDING
);
  localparam logic [11:0] SF_ALIGN = `FG_SF_ALIGN;
  localparam logic [5:0] ESF_ALIGN = `FG_ESF_ALIGN;
  localparam logic [7:0] DDS_PAT = `FG_DDS_PATTERN;

  stream_if #(.WIDTH(2)) fill_s ();
  stream_if #(.WIDTH(2)) drain_s ();

  fifo_buffer #(.WIDTH(2), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clk(I_CLK),
    .i_nrst(I_NRST),
    .i_ce(I_CE),
    .fill(fill_s),
    .drain(drain_s)
  );

  t1_j1_frame_generator_pkg::format_type fmt;
  logic [7:0] pos_q, pos_d, cur_pos, pm1;
  logic [4:0] frm_q, frm_d, cur_frm, last_frm;
  logic [2:0] ch_off;
  logic [3:0] dl_idx_q, dl_idx_d;
  logic [5:0] crc_acc_q, crc_acc_d, crc_tx_q, crc_tx_d, crc_seed;
  logic ft_pend_q, ft_pend_d, fs_pend_q, fs_pend_d;
  logic crc_pend_q, crc_pend_d, dds_pend_q, dds_pend_d;
  logic crc_act_q, crc_act_d, dds_act_q, dds_act_d;
  logic last_f_q, last_f_d, o_data_d, o_valid_d, hdlc_take_d;
  logic bf_d, mf_d, irq_d, yellow;
  logic fire, in_bit, fp, f_slot, odd_frame, mimic_slot, ch24, out_bit, mf_start;
  logic [15:0] idle_pat, yel_pat;

  assign fill_s.valid = I_VALID;
  assign fill_s.data = {I_FRAME_PULSE, I_DATA};
  assign O_READY = fill_s.ready;
  assign drain_s.ready = ~O_VALID | I_OUT_READY;
  assign fire = I_CE & drain_s.valid & drain_s.ready;
  assign fp = drain_s.data[1];
  assign in_bit = drain_s.data[0];

  always_comb begin
    fmt = t1_j1_frame_generator_pkg::format_type'(I_FORMAT);
    cur_pos = fp ? '0 : pos_q;
    cur_frm = fp ? '0 : frm_q;
    pm1 = cur_pos - 8'd1;
    ch_off = pm1[2:0];
    f_slot = (cur_pos == '0);
    mf_start = f_slot & (cur_frm == '0);
    odd_frame = ~cur_frm[0];
    ch24 = (cur_pos >= `FG_CH24_FIRST);
    mimic_slot = (cur_pos == 8'd1) & I_COPY_FRAMING_BIT_ENABLE & ~I_FRAMING_DISABLE;
    yellow = I_MANUAL_YELLOW_SEND | (I_AUTO_REMOTE_ALARM_ENABLE & I_RED_ALARM);
    idle_pat = I_J1_MODE ? `FG_J1_IDLE : `FG_T1_IDLE;
    yel_pat = I_J1_MODE ? `FG_J1_YELLOW : `FG_T1_YELLOW;
    last_frm = (fmt == t1_j1_frame_generator_pkg::FMT_ESF) ? `FG_ESF_LAST_FRAME :
               `FG_SF_LAST_FRAME;
  end

  always_comb begin
    out_bit = in_bit;
    ft_pend_d = ft_pend_q;
    fs_pend_d = fs_pend_q;
    crc_pend_d = crc_pend_q;
    dds_pend_d = dds_pend_q;
    crc_act_d = crc_act_q;
    dds_act_d = dds_act_q;
    dl_idx_d = dl_idx_q;
    hdlc_take_d = 1'b0;
    if (fire) begin
      if (mf_start) begin
        crc_act_d = 1'b0;
      end
      if (f_slot) begin
        dds_act_d = 1'b0;
      end
      unique case (fmt)
        t1_j1_frame_generator_pkg::FMT_SF, t1_j1_frame_generator_pkg::FMT_DM: begin
          if (f_slot && !I_FRAMING_DISABLE) begin
            out_bit = SF_ALIGN[`FG_SF_ALIGN_TOP - cur_frm[3:0]];
            if (fmt == t1_j1_frame_generator_pkg::FMT_SF && I_J1_MODE &&
                cur_frm == `FG_SF_LAST_FRAME) begin
              out_bit = yellow;
            end
            if (odd_frame && ft_pend_q) begin
              out_bit = ~out_bit;
              ft_pend_d = 1'b0;
            end else if (!odd_frame && fs_pend_q) begin
              out_bit = ~out_bit;
              fs_pend_d = 1'b0;
            end
          end
          if (fmt == t1_j1_frame_generator_pkg::FMT_SF && !I_J1_MODE && !f_slot &&
              ch_off == `FG_YELLOW_OFS && yellow) begin
            out_bit = 1'b0;
          end
          if (fmt == t1_j1_frame_generator_pkg::FMT_DM && ch24 && !I_FRAMING_DISABLE) begin
            if (ch_off == `FG_DM_D_OFS) begin
              if (!I_DATA_LINK_BYPASS && I_HDLC_VALID) begin
                out_bit = I_HDLC_BIT;
                hdlc_take_d = 1'b1;
              end
            end else if (ch_off == `FG_DM_Y_OFS) begin
              out_bit = ~yellow;
            end else begin
              if (cur_pos == `FG_CH24_FIRST && dds_pend_q) begin
                dds_act_d = 1'b1;
                dds_pend_d = 1'b0;
              end
              out_bit = DDS_PAT[`FG_DDS_TOP - ch_off] ^ dds_act_d;
            end
          end
        end
        t1_j1_frame_generator_pkg::FMT_ESF: begin
          if (f_slot && !I_FRAMING_DISABLE) begin
            if (cur_frm[1:0] == `FG_ESF_ALIGN_PHASE) begin
              out_bit = ESF_ALIGN[`FG_ESF_ALIGN_TOP - cur_frm[4:2]];
              if (fs_pend_q) begin
                out_bit = ~out_bit;
                fs_pend_d = 1'b0;
              end
            end else if (cur_frm[1:0] == `FG_ESF_CRC_PHASE) begin
              if (!I_CRC_INSERT_BYPASS) begin
                if (cur_frm == `FG_ESF_FIRST_CRC_FRAME && crc_pend_q) begin
                  crc_act_d = 1'b1;
                  crc_pend_d = 1'b0;
                end
                out_bit = crc_tx_q[`FG_ESF_ALIGN_TOP - cur_frm[4:2]] ^ crc_act_d;
              end
            end else if (yellow) begin
              out_bit = yel_pat[`FG_DL_TOP - dl_idx_q];
              dl_idx_d = dl_idx_q + 4'd1;
            end else if (!I_DATA_LINK_BYPASS) begin
              if (I_BOC_VALID) begin
                out_bit = I_BOC_BIT;
              end else if (I_PRM_VALID) begin
                out_bit = I_PRM_BIT;
              end else if (I_HDLC_VALID) begin
                out_bit = I_HDLC_BIT;
                hdlc_take_d = 1'b1;
              end else begin
                out_bit = idle_pat[`FG_DL_TOP - dl_idx_q];
                dl_idx_d = dl_idx_q + 4'd1;
              end
            end
          end
        end
        default: begin
          out_bit = in_bit;
        end
      endcase
      if (mimic_slot) begin
        out_bit = last_f_q;
      end
    end
    // A new request arriving in the cycle of its own use is kept for the next chance.
    ft_pend_d = ft_pend_d | I_TERMINAL_FRAMING_INVERT;
    fs_pend_d = fs_pend_d | I_SIGNALING_FRAMING_INVERT;
    crc_pend_d = crc_pend_d | I_CRC_PATTERN_INVERT;
    dds_pend_d = dds_pend_d | I_DDS_PATTERN_INVERT;
  end

  always_comb begin
    pos_d = pos_q;
    frm_d = frm_q;
    last_f_d = last_f_q;
    crc_acc_d = crc_acc_q;
    crc_tx_d = crc_tx_q;
    crc_seed = '0;
    o_data_d = O_DATA;
    o_valid_d = O_VALID & ~I_OUT_READY;
    bf_d = O_BASIC_FRAME_FLAG & ~I_BASIC_FRAME_FLAG_CLR;
    mf_d = O_MULTIFRAME_FLAG & ~I_MULTIFRAME_FLAG_CLR;
    if (fire) begin
      o_data_d = out_bit;
      o_valid_d = 1'b1;
      if (cur_pos == `FG_LAST_BIT) begin
        pos_d = '0;
        frm_d = (cur_frm == last_frm) ? '0 : cur_frm + 5'd1;
      end else begin
        pos_d = cur_pos + 8'd1;
        frm_d = cur_frm;
      end
      if (f_slot) begin
        last_f_d = out_bit;
        bf_d = 1'b1;
      end
      if (mf_start) begin
        mf_d = 1'b1;
        crc_tx_d = crc_acc_q;
      end else begin
        crc_seed = crc_acc_q;
      end
      // Framing bits enter the check sum as ones.
      crc_acc_d = {crc_seed[4:0], 1'b0} ^
                  ((crc_seed[5] ^ (f_slot | out_bit)) ? `FG_CRC_POLY : 6'h00);
    end
    irq_d = (bf_d & I_BASIC_FRAME_IRQ_ENABLE) | (mf_d & I_MULTIFRAME_IRQ_ENABLE);
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      pos_q <= '0;
      frm_q <= '0;
      dl_idx_q <= '0;
      crc_acc_q <= '0;
      crc_tx_q <= '0;
      ft_pend_q <= 1'b0;
      fs_pend_q <= 1'b0;
      crc_pend_q <= 1'b0;
      dds_pend_q <= 1'b0;
      crc_act_q <= 1'b0;
      dds_act_q <= 1'b0;
      last_f_q <= 1'b0;
      O_DATA <= 1'b0;
      O_VALID <= 1'b0;
      O_HDLC_TAKE <= 1'b0;
      O_BASIC_FRAME_FLAG <= 1'b0;
      O_MULTIFRAME_FLAG <= 1'b0;
      O_IRQ <= 1'b0;
      O_YELLOW_ACTIVE <= 1'b0;
      O_INVERT_PENDING <= '0;
    end else if (I_CE) begin
      pos_q <= pos_d;
      frm_q <= frm_d;
      dl_idx_q <= dl_idx_d;
      crc_acc_q <= crc_acc_d;
      crc_tx_q <= crc_tx_d;
      ft_pend_q <= ft_pend_d;
      fs_pend_q <= fs_pend_d;
      crc_pend_q <= crc_pend_d;
      dds_pend_q <= dds_pend_d;
      crc_act_q <= crc_act_d;
      dds_act_q <= dds_act_d;
      last_f_q <= last_f_d;
      O_DATA <= o_data_d;
      O_VALID <= o_valid_d;
      O_HDLC_TAKE <= hdlc_take_d;
      O_BASIC_FRAME_FLAG <= bf_d;
      O_MULTIFRAME_FLAG <= mf_d;
      O_IRQ <= irq_d;
      O_YELLOW_ACTIVE <= yellow;
      O_INVERT_PENDING <= {dds_pend_d, crc_pend_d, fs_pend_d, ft_pend_d};
    end
  end

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_NRST);

  sequence s_fbit_fire;
    fire && f_slot;
  endsequence
  sequence s_ft_used;
    s_fbit_fire ##0 (ft_pend_q && odd_frame && !I_FRAMING_DISABLE &&
                     fmt != t1_j1_frame_generator_pkg::FMT_ESF &&
                     !I_TERMINAL_FRAMING_INVERT);
  endsequence

  a_framing_disable_pass_fbit: assert property (s_fbit_fire ##0 I_FRAMING_DISABLE |=> O_DATA == $past(in_bit))
    else $error("framing bit altered while framing disabled");
  a_mimic_copy_bit: assert property (fire && mimic_slot |=> O_DATA == $past(last_f_q))
    else $error("mimic bit differs from framing bit");
  a_bf_flag_set: assert property (s_fbit_fire |=> O_BASIC_FRAME_FLAG)
    else $error("basic frame flag not set at frame start");
  a_mf_flag_set: assert property (fire && mf_start |=> O_MULTIFRAME_FLAG ##0 O_VALID)
    else $error("multiframe flag not set at multiframe start");
  a_irq_follows_flag: assert property (I_CE && bf_d && I_BASIC_FRAME_IRQ_ENABLE |=> O_IRQ)
    else $error("interrupt missing for enabled basic frame flag");
  a_t1_yellow_zero: assert property (fire && !f_slot && fmt == t1_j1_frame_generator_pkg::FMT_SF
    && !I_J1_MODE && ch_off == `FG_YELLOW_OFS && yellow |=> !O_DATA)
    else $error("yellow second channel bit not zero");
  a_dm_ybit_level: assert property (fire && ch24 && ch_off == `FG_DM_Y_OFS && !I_FRAMING_DISABLE
    && fmt == t1_j1_frame_generator_pkg::FMT_DM |=> O_DATA == !$past(yellow))
    else $error("channel 24 yellow bit wrong");
  a_esf_align_first: assert property (s_fbit_fire ##0 (fmt == t1_j1_frame_generator_pkg::FMT_ESF
    && !I_FRAMING_DISABLE && cur_frm == 5'd3 && !fs_pend_q) |=> !O_DATA)
    else $error("first alignment bit not zero");
  a_ft_invert_once: assert property (s_ft_used |=> !ft_pend_q ##0 O_VALID)
    else $error("terminal framing invert not cleared after use");
  a_out_hold_stall: assert property (O_VALID && !I_OUT_READY |=> O_VALID && $stable(O_DATA))
    else $error("output changed while stalled");
endmodule
`default_nettype wire

// ### bench/frame_partner.sv
// Partner model: upstream payload source and downstream line-encoder sink.
// Assumes the generator's clock and active-low reset; records the first 9264 output bits.
`timescale 1ns/1ns
`default_nettype none
module frame_partner (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_fill,
  input wire logic i_esf,
  input wire logic i_slow,
  input wire logic i_ready,
  output logic o_valid,
  output logic o_data,
  output logic o_pulse,
  input wire logic i_valid,
  input wire logic i_data,
  output logic o_ready,
  output var int o_count,
  output var int o_refused
);
  int pos;
  logic out_bits [0:9263];
  assign o_data = i_fill;
  // The pulse marks the F bit of frame 1 so that the counters stay aligned.
  assign o_pulse = o_valid && pos == 0;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pos <= 0;
      o_valid <= 1'b0;
      o_ready <= 1'b0;
      o_count <= 0;
      o_refused <= 0;
    end else begin
      o_valid <= 1'b1;
      if (o_valid && i_ready) begin
        pos <= (pos == (i_esf ? 4631 : 2315)) ? 0 : pos + 1;
      end
      if (o_valid && !i_ready) begin
        o_refused <= o_refused + 1;
      end
      // A slow encoder accepts on every other cycle, so the buffer fills up.
      o_ready <= i_slow ? !o_ready : 1'b1;
      if (i_valid && o_ready && o_count < 9264) begin
        out_bits[o_count] <= i_data;
        o_count <= o_count + 1;
      end
    end
  end
endmodule
`default_nettype wire

// ### bench/t1_j1_frame_generator_bench.sv
// Self-checking bench for the T1/J1 frame generator.
// Assumes the partner model supplies the stream and records the first 9264 output bits.
`timescale 1ns/1ns
`default_nettype none
module t1_j1_frame_generator_bench;
  localparam logic [1:0] SF = t1_j1_frame_generator_pkg::FMT_SF;
  localparam logic [1:0] ESF = t1_j1_frame_generator_pkg::FMT_ESF;
  localparam logic [1:0] DM = t1_j1_frame_generator_pkg::FMT_DM;
  localparam logic [11:0] ALIGN = 12'h8DC;
  localparam logic [5:0] EALIGN = 6'h0B;
  logic clk, nrst, fill, slow, j1, framing_disable, ft, fs, crci, ddsi, mimic, yel, ayel, red;
  logic crc_insert_bypass, dlbyp, boc_v, boc_b, prm_v, prm_b, hd_v, hd_b, bf_clr, mf_clr, bf_en, mf_en;
  logic [1:0] fmt;
  logic in_v, in_d, pulse, rdy, dout, dval, out_rdy, take, bf, mf, irq, yact;
  logic [3:0] pend;
  int cnt, refused, take_count;
  int bad_count = 0;
  int num_checks = 0;

  frame_partner pt (.i_clk(clk), .i_nrst(nrst), .i_fill(fill), .i_esf(fmt == ESF),
    .i_slow(slow), .i_ready(rdy), .o_valid(in_v), .o_data(in_d), .o_pulse(pulse),
    .i_valid(dval), .i_data(dout), .o_ready(out_rdy), .o_count(cnt), .o_refused(refused));

  t1_j1_frame_generator dut (.I_CLK(clk), .I_NRST(nrst), .I_CE(1'b1), .I_DATA(in_d),
    .I_FRAME_PULSE(pulse), .I_VALID(in_v), .O_READY(rdy), .O_DATA(dout), .O_VALID(dval),
    .I_OUT_READY(out_rdy), .I_FORMAT(fmt), .I_J1_MODE(j1), .I_FRAMING_DISABLE(framing_disable),
    .I_TERMINAL_FRAMING_INVERT(ft), .I_SIGNALING_FRAMING_INVERT(fs),
    .I_CRC_PATTERN_INVERT(crci), .I_DDS_PATTERN_INVERT(ddsi),
    .I_COPY_FRAMING_BIT_ENABLE(mimic), .I_MANUAL_YELLOW_SEND(yel),
    .I_AUTO_REMOTE_ALARM_ENABLE(ayel), .I_RED_ALARM(red), .I_CRC_INSERT_BYPASS(crc_insert_bypass),
    .I_DATA_LINK_BYPASS(dlbyp), .I_BOC_VALID(boc_v), .I_BOC_BIT(boc_b),
    .I_PRM_VALID(prm_v), .I_PRM_BIT(prm_b), .I_HDLC_VALID(hd_v), .I_HDLC_BIT(hd_b),
    .O_HDLC_TAKE(take), .I_BASIC_FRAME_FLAG_CLR(bf_clr), .I_MULTIFRAME_FLAG_CLR(mf_clr),
    .I_BASIC_FRAME_IRQ_ENABLE(bf_en), .I_MULTIFRAME_IRQ_ENABLE(mf_en),
    .O_BASIC_FRAME_FLAG(bf), .O_MULTIFRAME_FLAG(mf), .O_IRQ(irq),
    .O_YELLOW_ACTIVE(yact), .O_INVERT_PENDING(pend));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Counts the HDLC bits that the generator reports as taken since the last reset.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      take_count <= 0;
    end else if (take) begin
      take_count <= take_count + 1;
    end
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic chk1(input logic seen, input logic exp);
    check({15'h0000, seen}, {15'h0000, exp});
  endtask

  function automatic logic ob(input int p);
    return pt.out_bits[p];
  endfunction

  // Bits 8..1 of channel 24 in frame f, bit 8 being sent first.
  function automatic logic [7:0] ch24(input int f);
    for (int k = 1; k <= 8; k++) ch24[k-1] = ob(f * 193 - k);
  endfunction

  // Vector order: j1 framing_disable mimic yel ayel red crc_insert_bypass dlbyp boc_v boc_b prm_v prm_b
  // hd_v hd_b bf_en mf_en.
  task automatic cfg(input logic [1:0] f, input logic fl, input logic sl,
      input logic [15:0] v);
    @(posedge clk);
    fmt <= f;
    fill <= fl;
    slow <= sl;
    {j1, framing_disable, mimic, yel, ayel, red, crc_insert_bypass, dlbyp} <= v[15:8];
    {boc_v, boc_b, prm_v, prm_b, hd_v, hd_b, bf_en, mf_en} <= v[7:0];
  endtask

  // Resets, arms the one-shot inverts in m = {dds, crc, fs, ft}, waits for n bits.
  task automatic run(input int n, input logic [3:0] m);
    int k;
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    {ddsi, crci, fs, ft} <= m;
    @(posedge clk);
    {ddsi, crci, fs, ft} <= 4'h0;
    for (k = 0; k < 3 * n + 99 && cnt < n; k++) @(posedge clk);
    #1;
    if (cnt < n) begin
      bad_count++;
      $display("[ERR] %0t stream stalled", $time);
      stop_test();
    end
  endtask

  task automatic sc_sf();
    int flips;
    flips = 0;
    cfg(SF, 1'b0, 1'b0, 16'h2002);
    run(2316, 4'h1);
    for (int f = 1; f <= 12; f++) begin
      if (f % 2 == 1 && ob(f * 193 - 193) !== ALIGN[12-f]) flips++;
      else chk1(ob(f * 193 - 193), ALIGN[12-f]);
      chk1(ob(f * 193 - 192), ob(f * 193 - 193));
    end
    check(16'(flips), 16'h0001);
    check({12'h000, pend}, 16'h0000);
    chk1(bf, 1'b1);
    chk1(irq, 1'b1);
    chk1(mf, 1'b1);
    @(posedge clk);
    bf_clr <= 1'b1;
    mf_clr <= 1'b1;
    @(posedge clk);
    bf_clr <= 1'b0;
    mf_clr <= 1'b0;
    @(posedge clk);
    #1;
    chk1(bf, 1'b0);
    chk1(mf, 1'b0);
    chk1(irq, 1'b0);
  endtask

  task automatic sc_j1(input logic y);
    cfg(SF, 1'b1, 1'b0, {3'b100, y, 12'h000});
    run(2316, 4'h0);
    for (int f = 1; f <= 11; f++) chk1(ob(f * 193 - 193), ALIGN[12-f]);
    chk1(ob(11 * 193), y);
    chk1(yact, y);
  endtask

  task automatic sc_yel(input logic a);
    cfg(SF, 1'b1, a, {4'h0, a, 1'b1, 10'h000});
    run(2316, 4'h0);
    for (int c = 1; c <= 24; c++) begin
      chk1(ob(772 + 8 * c - 6), !a);
      chk1(ob(772 + 8 * c - 7), 1'b1);
    end
    chk1(yact, a);
    chk1(refused > 0 || !a, 1'b1);
  endtask

  task automatic sc_dm(input logic y);
    int flips;
    logic [7:0] e;
    flips = 0;
    e = {2'b01, !y, 5'b11101};
    cfg(DM, 1'b0, 1'b0, {3'b000, y, 12'h00C});
    run(2316, 4'hA);
    for (int f = 1; f <= 12; f++) begin
      if (f % 2 == 0 && ob(f * 193 - 193) !== ALIGN[12-f]) flips++;
      else chk1(ob(f * 193 - 193), ALIGN[12-f]);
    end
    check(16'(flips), 16'h0001);
    check({8'h00, ch24(1)}, {8'h00, e ^ 8'h9F});
    check({8'h00, ch24(2)}, {8'h00, e});
    check(16'(take_count), 16'h000C);
    chk1(irq, 1'b0);
  endtask

  task automatic sc_framing_disable();
    int wrong;
    wrong = 0;
    cfg(DM, 1'b1, 1'b0, 16'h6008);
    run(2316, 4'hF);
    for (int p = 0; p < 2316; p++) if (ob(p) !== 1'b1) wrong++;
    check(16'(wrong), 16'h0000);
    check(16'(take_count), 16'h0000);
  endtask

  task automatic sc_esf();
    int flips;
    logic [5:0] crc;
    logic fb;
    flips = 0;
    crc = 6'h00;
    cfg(ESF, 1'b0, 1'b0, 16'h0001);
    run(9264, 4'h6);
    for (int p = 0; p < 4632; p++) begin
      fb = crc[5] ^ ((p % 193 == 0) ? 1'b1 : ob(p));
      crc = {crc[4:0], 1'b0} ^ (fb ? 6'h03 : 6'h00);
    end
    for (int i = 0; i < 6; i++) begin
      if (ob((4 * i + 3) * 193) !== EALIGN[5-i]) flips++;
      chk1(ob(4632 + (4 * i + 3) * 193), EALIGN[5-i]);
      chk1(ob((4 * i + 1) * 193), 1'b1);
      chk1(ob(4632 + (4 * i + 1) * 193), crc[5-i]);
    end
    check(16'(flips), 16'h0001);
    check({12'h000, pend}, 16'h0000);
    chk1(irq, 1'b1);
  endtask

  // s = {j1, yel, boc_v, prm_v, hd_v, dlbyp}; the code bit is 1, report 0, HDLC 1.
  task automatic sc_dl(input logic [5:0] s, input logic [11:0] e);
    cfg(ESF, 1'b0, 1'b0, {s[5], 2'b00, s[4], 3'b001, s[0], s[3], 1'b1, s[2], 1'b0,
      s[1], 1'b1, 2'b00});
    run(4632, 4'h0);
    for (int i = 0; i < 12; i++) chk1(ob(2 * i * 193), e[11-i]);
  endtask

  initial begin
    nrst = 1'b0;
    fmt = SF;
    {fill, slow, ddsi, crci, fs, ft, bf_clr, mf_clr} = 8'h00;
    {j1, framing_disable, mimic, yel, ayel, red, crc_insert_bypass, dlbyp} = 8'h00;
    {boc_v, boc_b, prm_v, prm_b, hd_v, hd_b, bf_en, mf_en} = 8'h00;
    @(posedge clk);
    sc_sf();
    sc_j1(1'b0);
    sc_j1(1'b1);
    sc_yel(1'b0);
    sc_yel(1'b1);
    sc_dm(1'b0);
    sc_dm(1'b1);
    sc_framing_disable();
    sc_esf();
    sc_dl(6'b011000, 12'hFF0);
    sc_dl(6'b110001, 12'hFFF);
    sc_dl(6'b001110, 12'hFFF);
    sc_dl(6'b000110, 12'h000);
    sc_dl(6'b100010, 12'hFFF);
    sc_dl(6'b100000, 12'hFF7);
    sc_dl(6'b000000, 12'hFFF);
    sc_dl(6'b001001, 12'h000);
    stop_test();
  end
endmodule
`default_nettype wire
